// [bench/lsdcr_mcu_model.sv]
/* Microcontroller model driving the serial register port.
   Assumes the bank samples sclk with clk; each sclk half lasts 4 clk. */
`timescale 1ns/100ps
module lsdcr_mcu_model (
   // Clock
   input  wire logic clk,
   // Serial port
   output logic      cs_n,
   output logic      sclk,
   output logic      mosi,
   input  wire logic miso
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // One frame msb first; r holds the answer to the frame before
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      @(posedge clk);
      cs_n <= 1'b0;
      for (int k = 15; k >= 0; k--) begin
         mosi <= w[k];
         repeat (4) @(posedge clk);
         r[k] = miso;
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (2) @(posedge clk);
   endtask
endmodule // lsdcr_mcu_model

// [bench/lsdcr_regs_sva.sv]
/* Port checker for the low-side driver register bank.
   Assumes one clock domain; bound to lsdcr_regs below. */
`timescale 1ns/100ps
module lsdcr_regs_sva
   import lsdcr_pkg::*;
(
   // Clock, reset, enable
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ce,
   // Pins
   input wire logic [3:0]  ls_pin,
   input wire logic        key_switch,
   input wire logic        tach_overcurrent,
   // Outputs
   input lsdcr_drive_t     drive,
   input lsdcr_diag_t      diag,
   input lsdcr_sys_t       sys,
   input lsdcr_tach_mode_t tach_mode
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   AST_RST_OUT: assert property (
      $rose(reset_n) |-> drive == 6'h00 && sys == 8'h00 && tach_mode == LSDCR_TM_DIV)
      else $error("outputs not cleared by reset");
   AST_RST_DEF: assert property (
      $rose(reset_n) && ce |=> sys.sensor_supply_on && diag.inrush_long == 6'h20
         && diag.sink_en == 6'h2F)
      else $error("reset defaults not shown");
   AST_OL_GATED: assert property (
      (diag.open_load_flag & ~diag.sink_en) == 6'h00)
      else $error("open load flag without sink");
   AST_TACH_DIAG: assert property (
      $past(ce) && $past(tach_mode) != LSDCR_TM_LSD |-> !diag.sink_en[4] && !diag.inrush_long[4])
      else $error("tach diag bits outside low-side mode");
   AST_MODE_HOT: assert property (
      $onehot(tach_mode))
      else $error("tach mode not one-hot");
   AST_PIN_OR: assert property (
      $past(ce) && $past(reset_n) && $past(ls_pin[0]) |-> drive.injector_a_output)
      else $error("injector A pin not ORed in");
   AST_RELB_KEY: assert property (
      $past(ce) && !$past(key_switch) && !sys.power_hold_en |-> !drive.relay_b_output)
      else $error("relay B on with key open and no hold");
   AST_TRIP: assert property (
      ce && tach_overcurrent && drive.tach_output ##1 ce |=> !drive.tach_output)
      else $error("tach not shut off on overcurrent");
   AST_INTRST: assert property (
      ce && sys.internal_reset |=> !sys.internal_reset)
      else $error("internal reset longer than one cycle");
endmodule // lsdcr_regs_sva

bind lsdcr_regs lsdcr_regs_sva u_sva (.clk, .reset_n, .ce, .ls_pin, .key_switch,
   .tach_overcurrent, .drive, .diag, .sys, .tach_mode);

// [bench/test_lowside_driver_control_regs.sv]
/* Self-checking bench for the low-side driver register bank.
   Assumes the microcontroller model drives the serial port. */
`timescale 1ns/100ps
`include "lsdcr_defs.svh"
module test_lowside_driver_control_regs
   import lsdcr_pkg::*;
;
   logic             clk = 1'b0;
   logic             reset_n = 1'b0;
   logic             ce = 1'b1;
   logic [3:0]       ls_pin = 4'h0;
   logic             speed_pulse = 1'b0;
   logic             key_switch = 1'b0;
   logic             tach_overcurrent = 1'b0;
   logic [5:0]       open_load_raw = 6'h00;
   logic             cs_n, sclk, mosi, miso;
   lsdcr_drive_t     drive;
   lsdcr_diag_t      diag;
   lsdcr_sys_t       sys;
   lsdcr_tach_mode_t tach_mode;
   int               error_cnt = 0;
   int               num_checks = 0;
   int               cyc = 0;
   logic [4:0]       spd = 5'h00;

   always #5 clk = ~clk;
   // Speed pulse toggles every 10 clk; cycle ceiling ends a hung run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      spd <= (spd == 5'h09) ? 5'h00 : spd + 5'h01;
      if (spd == 5'h09)
         speed_pulse <= ~speed_pulse;
      if (cyc == 90000) begin
         error_cnt++;
         complete_run();
      end
   end

   lsdcr_regs #(.PWM_LOW_STEP_CYC(20), .OSC_HALF0_CYC(40), .OSC_HALF1_CYC(30),
      .OSC_HALF2_CYC(20), .OSC_HALF3_CYC(10)) DUT (.clk, .reset_n,
      .ce, .cs_n, .sclk, .mosi, .miso, .ls_pin, .speed_pulse, .key_switch,
      .tach_overcurrent, .open_load_raw, .drive, .diag, .sys, .tach_mode);
   lsdcr_mcu_model mcu (.clk, .cs_n, .sclk, .mosi, .miso);

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [1:0] sp, logic [3:0] a, logic [7:0] d);
      logic [15:0] r;
      mcu.xfer({2'b10, sp, a, d}, r);
   endtask
   // Read answer comes in the next frame with the header echoed
   task automatic rd_chk(logic [1:0] sp, logic [3:0] a, logic [7:0] exp);
      logic [15:0] r;
      mcu.xfer({2'b00, sp, a, 8'h00}, r);
      mcu.xfer(16'h0000, r);
      chk("register", r, {2'b00, sp, a, exp});
   endtask
   // High cycles of one output over n clocks, after n clocks to settle
   task automatic duty_chk(int idx, int n, int exp);
      int h;
      h = 0;
      repeat (n) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         if (drive[idx] === 1'b1)
            h++;
      end
      chk("high cycles", 16'(h), 16'(exp));
   endtask
   // Rise-to-rise period of the tach output
   task automatic per_chk(int exp);
      logic p;
      int   n, k;
      p = drive.tach_output;
      n = 0;
      k = 0;
      while (k < 2 && n < 20000) begin
         @(posedge clk);
         n++;
         if (drive.tach_output === 1'b1 && p === 1'b0) begin
            k++;
            if (k == 1)
               n = 0;
         end
         p = drive.tach_output;
      end
      chk("tach period", 16'(n), 16'(exp));
   endtask

   task automatic s_reset();
      chk("mode", 16'(tach_mode), 16'(LSDCR_TM_DIV));
      rd_chk(2'h1, 4'h0, 8'h00);
      rd_chk(2'h1, 4'h1, 8'h12);
      rd_chk(2'h0, 4'h4, 8'h01);
      rd_chk(2'h0, 4'h5, 8'h18);
      rd_chk(2'h1, 4'h6, 8'h00);
   endtask
   task automatic s_regs();
      wr(2'h0, 4'h5, 8'hFF);
      rd_chk(2'h0, 4'h5, 8'h9B);
      wr(2'h0, 4'h5, 8'h18);
      wr(2'h0, 4'h3, 8'hFF);
      rd_chk(2'h0, 4'h3, 8'hDF);
      wr(2'h0, 4'h3, 8'h10);
      wr(2'h1, 4'h1, 8'hFF);
      rd_chk(2'h1, 4'h1, 8'hD6);
      chk("sys", sys, 8'hF0);
      wr(2'h1, 4'h1, 8'h12);
      wr(2'h2, 4'h0, 8'hFF);
      rd_chk(2'h2, 4'h0, 8'h00);
      for (int i = 2; i < 8; i++) begin
         wr(2'h1, 4'(i), 8'(8'h80 + i * 13));
         rd_chk(2'h1, 4'(i), 8'(i * 13));
      end
   endtask
   task automatic s_logic();
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         wr(2'h0, 4'h1, a[2] ? 8'h14 : 8'h10);
         wr(2'h1, 4'h0, {1'b0, a[1], 2'b00, a[1], a[1], a[1], a[1]});
         ls_pin <= {2'b00, a[0], a[0]};
         repeat (3) @(posedge clk);
         chk("inj b", drive.injector_b_output, a[2] ? a[1] & a[0] : a[1] | a[0]);
         chk("lamp", drive.lamp_output, a[1]);
         chk("pre", sys[2:0], {3{a[1]}});
      end
      ls_pin <= 4'h0;
   endtask
   task automatic s_relay();
      wr(2'h1, 4'h0, 8'h10);
      chk("relay b", drive.relay_b_output, 1'b0);
      wr(2'h0, 4'h3, 8'h50);
      wr(2'h1, 4'h1, 8'h92);
      chk("relay b", drive.relay_b_output, 1'b1);
      wr(2'h0, 4'h3, 8'h10);
      chk("relay b", drive.relay_b_output, 1'b0);
      key_switch <= 1'b1;
      wr(2'h1, 4'h1, 8'h12);
      chk("relay b", drive.relay_b_output, 1'b1);
   endtask
   task automatic s_pwm();
      int dv [4] = '{0, 50, 100, 127};
      wr(2'h0, 4'h2, 8'h11);
      wr(2'h1, 4'h0, 8'h20);
      foreach (dv[i]) begin
         wr(2'h1, 4'h4, 8'(dv[i]));
         duty_chk(2, 2000, dv[i] > 100 ? 2000 : dv[i] * 20);
      end
   endtask
   task automatic s_tach();
      int half [7] = '{40, 30, 20, 10, `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F4_HZ),
         `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F5_HZ), `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F6_HZ)};
      for (int k = 0; k < 7; k++) begin
         wr(2'h0, 4'h4, 8'(8'h20 + k));
         chk("mode", 16'(tach_mode), 16'(LSDCR_TM_OSC));
         per_chk(2 * half[k]);
      end
      wr(2'h0, 4'h4, 8'h03);
      chk("mode", 16'(tach_mode), 16'(LSDCR_TM_DIV));
      per_chk(60);
      wr(2'h0, 4'h4, 8'h00);
      per_chk(640);
      open_load_raw <= 6'h3F;
      wr(2'h1, 4'h6, 8'h19);
      wr(2'h0, 4'h4, 8'h59);
      chk("mode", 16'(tach_mode), 16'(LSDCR_TM_LSD));
      chk("tach diag", {diag.sink_en[4], diag.inrush_long[4], diag.open_load_flag[4]}, 3'h7);
      duty_chk(5, 2000, 500);
      wr(2'h0, 4'h4, 8'h40);
      duty_chk(5, 100, 100);
      wr(2'h0, 4'h4, 8'h43);
      chk("tach ol", {diag.sink_en[4], diag.open_load_flag[4]}, 2'h0);
      duty_chk(5, 100, 100);
      tach_overcurrent <= 1'b1;
      @(posedge clk);
      tach_overcurrent <= 1'b0;
      duty_chk(5, 100, 0);
      wr(2'h1, 4'h1, 8'h10);
      chk("tach", drive.tach_output, 1'b0);
      wr(2'h1, 4'h1, 8'h12);
      duty_chk(5, 100, 100);
      wr(2'h0, 4'h4, 8'hC3);
      chk("retry", diag.retry_en, 6'h10);
      tach_overcurrent <= 1'b1;
      @(posedge clk);
      tach_overcurrent <= 1'b0;
      repeat (2) @(posedge clk);
      chk("tach", drive.tach_output, 1'b0);
      repeat (2010) @(posedge clk);
      chk("tach", drive.tach_output, 1'b1);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      s_reset();
      s_regs();
      s_logic();
      s_relay();
      s_pwm();
      s_tach();
      complete_run();
   end
endmodule // test_lowside_driver_control_regs

// [include/lsdcr_defs.svh]
/*
 Constants for the low-side driver control register bank: frame layout,
 register offsets, field positions, reset values, write masks and timing.
 Assumes a 100 MHz system clock.
*/
`ifndef LSDCR_DEFS_SVH
`define LSDCR_DEFS_SVH

// Serial frame layout
`define LSDCR_FRM_WRITE      15
`define LSDCR_FRM_SPACE_HI   13
`define LSDCR_FRM_SPACE_LO   12
`define LSDCR_FRM_REG_HI     11
`define LSDCR_FRM_REG_LO     8
`define LSDCR_FRM_BITS       5'h10
`define LSDCR_SPACE_CFG      2'h0
`define LSDCR_SPACE_CTL      2'h1

// Configuration space offsets
`define LSDCR_CFG_TACH       4'h4
`define LSDCR_CFG_LAST       4'h5
// Control space offsets
`define LSDCR_CTL_MAIN       4'h0
`define LSDCR_CTL_AUX        4'h1
`define LSDCR_CTL_DUTY_FIRST 4'h2
`define LSDCR_CTL_DUTY_LAST  4'h7

// Configuration fields
`define LSDCR_CFG_RETRY      7
`define LSDCR_CFG_SDD        6
`define LSDCR_CFG_MODE_LSD   6
`define LSDCR_CFG_MODE_OSC   5
`define LSDCR_CFG_SINK       4
`define LSDCR_CFG_INRUSH     3
`define LSDCR_CFG_ORAND      2
// Auxiliary and main control fields
`define LSDCR_AUX_PWRHOLD    7
`define LSDCR_AUX_SELFTEST   6
`define LSDCR_AUX_VSENS      4
`define LSDCR_AUX_BATSW      2
`define LSDCR_AUX_TACH       1
`define LSDCR_AUX_INTRST     0
`define LSDCR_MAIN_SPARK_A   2
`define LSDCR_MAIN_SPARK_B   1
`define LSDCR_MAIN_HEATER    0

// Reset values
`define LSDCR_CFG_RST        8'h10
`define LSDCR_LAMP_CFG_RST   8'h18
`define LSDCR_TACH_CFG_RST   8'h01
`define LSDCR_MAIN_RST       8'h00
`define LSDCR_AUX_RST        8'h12
`define LSDCR_DUTY_RST       7'h00

// Writable bits
`define LSDCR_CFG_MASK       8'h9F
`define LSDCR_REL_B_CFG_MASK 8'hDF
`define LSDCR_LAMP_CFG_MASK  8'h9B
`define LSDCR_TACH_CFG_MASK  8'hFF
`define LSDCR_AUX_MASK       8'hD7

// Timing
`define LSDCR_CLK_HZ         100000000
`define LSDCR_CLK_MHZ        100
`define LSDCR_DUTY_FULL      7'h64
`define LSDCR_PWM_LOW_STEP_US  100
`define LSDCR_PWM_HIGH_STEP_US 10
`define LSDCR_OSC_F0_HZ      10
`define LSDCR_OSC_F1_HZ      100
`define LSDCR_OSC_F2_HZ      1000
`define LSDCR_OSC_F3_HZ      5000
`define LSDCR_OSC_F4_HZ      10000
`define LSDCR_OSC_F5_HZ      20000
`define LSDCR_OSC_F6_HZ      40000
`define LSDCR_OSC_F7_HZ      100000

`endif

// [include/lsdcr_pkg.sv]
/*
 Types of the low-side driver control register bank.
 Assumes lsdcr_defs.svh is on the include path.
*/
package lsdcr_pkg;

   typedef enum logic [2:0] {
      LSDCR_TM_DIV = 3'b001,
      LSDCR_TM_OSC = 3'b010,
      LSDCR_TM_LSD = 3'b100
   } lsdcr_tach_mode_t;

   typedef struct packed {
      logic tach_output;
      logic lamp_output;
      logic relay_b_output;
      logic relay_a_output;
      logic injector_b_output;
      logic injector_a_output;
   } lsdcr_drive_t;

   typedef struct packed {
      logic [5:0] sink_en;
      logic [5:0] inrush_long;
      logic [5:0] retry_en;
      logic [5:0] open_load_flag;
   } lsdcr_diag_t;

   typedef struct packed {
      logic power_hold_en;
      logic power_on_selftest;
      logic sensor_supply_on;
      logic battery_switch_on;
      logic internal_reset;
      logic spark_a_on;
      logic spark_b_on;
      logic heater_on;
   } lsdcr_sys_t;

   typedef struct packed {
      logic        sclk_q;
      logic [4:0]  bit_cnt;
      logic [15:0] rx;
      logic [15:0] tx;
   } lsdcr_spi_t;

   typedef struct packed {
      logic [5:0][7:0] cfg;
      logic [7:0]      main_onoff;
      logic [7:0]      aux_onoff;
      logic [5:0][6:0] duty;
      lsdcr_spi_t      spi;
      logic [13:0]     pre_low;
      logic [6:0]      pct_low;
      logic [13:0]     pre_high;
      logic [6:0]      pct_high;
      logic [22:0]     osc_cnt;
      logic            osc_out;
      logic            speed_q;
      logic [4:0]      div_cnt;
      logic            tach_trip;
      lsdcr_drive_t    drive;
      lsdcr_diag_t     diag;
      lsdcr_sys_t      sys;
   } lsdcr_state_t;

endpackage

// [src/lsdcr_regs.sv]
/*
 Register bank and output logic for the low-side drivers, the tachometer
 output and the pre-driver commands, reached over a 16-bit serial port.
 Assumes all pin inputs, the serial clock among them, are synchronous to clk.
*/
`timescale 1ns/100ps
`include "lsdcr_defs.svh"

module lsdcr_regs
   import lsdcr_pkg::*;
#(
   parameter int unsigned PWM_LOW_STEP_CYC = `LSDCR_PWM_LOW_STEP_US * `LSDCR_CLK_MHZ,
   parameter int unsigned OSC_HALF0_CYC    = `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F0_HZ),
   parameter int unsigned OSC_HALF1_CYC    = `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F1_HZ),
   parameter int unsigned OSC_HALF2_CYC    = `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F2_HZ),
   parameter int unsigned OSC_HALF3_CYC    = `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F3_HZ),
   parameter int unsigned OSC_HALF4_CYC    = `LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F4_HZ)
) (
   // Clock, reset, enable
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   // Serial register port
   input  wire logic         cs_n,
   input  wire logic         sclk,
   input  wire logic         mosi,
   output logic              miso,
   // Parallel inputs and field sensing
   input  wire logic [3:0]   ls_pin,
   input  wire logic         speed_pulse,
   input  wire logic         key_switch,
   input  wire logic         tach_overcurrent,
   input  wire logic [5:0]   open_load_raw,
   // Driver commands
   output lsdcr_drive_t      drive,
   output lsdcr_diag_t       diag,
   output lsdcr_sys_t        sys,
   output lsdcr_tach_mode_t  tach_mode
);

   localparam logic [13:0] LOW_STEP_M1  = 14'(PWM_LOW_STEP_CYC - 1);
   localparam logic [13:0] HIGH_STEP_M1 =
      14'(`LSDCR_PWM_HIGH_STEP_US * `LSDCR_CLK_MHZ - 1);
   localparam logic [22:0] OSC_HALF5_M1 =
      23'(`LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F5_HZ) - 1);
   localparam logic [22:0] OSC_HALF6_M1 =
      23'(`LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F6_HZ) - 1);
   localparam logic [22:0] OSC_HALF7_M1 =
      23'(`LSDCR_CLK_HZ / (2 * `LSDCR_OSC_F7_HZ) - 1);

   lsdcr_state_t st_ff;
   lsdcr_state_t nxt_st;
   logic [5:0]   drv_nxt;
   logic [5:0]   duty_low_hi;
   logic [5:0]   duty_high_hi;
   logic         tach_lsd;

   assign miso      = st_ff.spi.tx[15];
   assign drive     = st_ff.drive;
   assign diag      = st_ff.diag;
   assign sys       = st_ff.sys;
   // Bit 6 is tested first, so mode code 11 acts as low-side mode
   assign tach_mode = lsdcr_tach_mode_t'(
      st_ff.cfg[`LSDCR_CFG_TACH][`LSDCR_CFG_MODE_LSD] ? LSDCR_TM_LSD :
      st_ff.cfg[`LSDCR_CFG_TACH][`LSDCR_CFG_MODE_OSC] ? LSDCR_TM_OSC :
      LSDCR_TM_DIV);
   assign tach_lsd  = (tach_mode == LSDCR_TM_LSD);

   // Oscillator half period, minus one, for each frequency code
   function automatic logic [22:0] osc_half_m1(input logic [2:0] code);
      logic [22:0] half;
      half = OSC_HALF7_M1;
      unique case (code)
         3'h0: half = 23'(OSC_HALF0_CYC - 1);
         3'h1: half = 23'(OSC_HALF1_CYC - 1);
         3'h2: half = 23'(OSC_HALF2_CYC - 1);
         3'h3: half = 23'(OSC_HALF3_CYC - 1);
         3'h4: half = 23'(OSC_HALF4_CYC - 1);
         3'h5: half = OSC_HALF5_M1;
         3'h6: half = OSC_HALF6_M1;
         3'h7: half = OSC_HALF7_M1;
      endcase
      return half;
   endfunction

   // Writable bits of each configuration register
   function automatic logic [7:0] cfg_mask(input logic [3:0] idx);
      logic [7:0] m;
      unique case (idx)
         4'h3:            m = `LSDCR_REL_B_CFG_MASK;
         `LSDCR_CFG_TACH: m = `LSDCR_TACH_CFG_MASK;
         `LSDCR_CFG_LAST: m = `LSDCR_LAMP_CFG_MASK;
         default:         m = `LSDCR_CFG_MASK;
      endcase
      return m;
   endfunction

   // Per-driver output except the tach (tied to 0 here): pin/control combination, then internal PWM gating
   genvar g;
   for (g = 0; g < 6; g++) begin : g_drv
      localparam int ONB = (g == 5) ? 3 : 7 - g;
      logic [6:0] dv;
      assign dv = st_ff.duty[g];
      assign duty_low_hi[g]  = (dv >= `LSDCR_DUTY_FULL) | (st_ff.pct_low < dv);
      assign duty_high_hi[g] = (dv >= `LSDCR_DUTY_FULL) | (st_ff.pct_high < dv);
      if (g == 4) begin : g_tach
         assign drv_nxt[g] = 1'b0;
      end else begin : g_ls
         logic on_bit;
         logic pin;
         logic combo;
         logic gated;
         assign on_bit = st_ff.main_onoff[ONB];
         if (g == 5) begin : g_lamp
            assign pin   = 1'b0;
            assign combo = pin | on_bit;
         end else begin : g_pin
            assign pin   = ls_pin[g];
            assign combo = st_ff.cfg[g][`LSDCR_CFG_ORAND] ? (pin & on_bit)
                                                          : (pin | on_bit);
         end
         // Internal PWM gating; code 11 is treated as no PWM
         assign gated = (st_ff.cfg[g][1:0] == 2'b01) ? (combo & duty_low_hi[g]) :
                        (st_ff.cfg[g][1:0] == 2'b10) ? (combo & duty_high_hi[g]) :
                        combo;
         if (g == 3) begin : g_relb
            // Without the key, only shutdown disable with power hold keeps it on
            assign drv_nxt[g] = gated & (key_switch |
               (st_ff.cfg[g][`LSDCR_CFG_SDD] &
                st_ff.aux_onoff[`LSDCR_AUX_PWRHOLD]));
         end else begin : g_plain
            assign drv_nxt[g] = gated;
         end
      end
   end

   always_comb begin
      logic [15:0] word;
      logic [1:0]  space;
      logic [3:0]  idx;
      logic [7:0]  rdata;
      logic        rise;
      logic        fall;
      logic        low_wrap;
      logic        high_wrap;
      logic        speed_rise;
      logic [5:0]  div_n;
      logic [4:0]  div_inc;
      logic        div_out;
      logic        tach_src;
      logic [7:0]  tc;
      logic [6:0]  duty_idx;
      word       = 16'h0000;
      space      = 2'h0;
      idx        = 4'h0;
      rdata      = 8'h00;
      duty_idx   = 7'h00;
      low_wrap   = 1'b0;
      high_wrap  = 1'b0;
      speed_rise = 1'b0;
      div_n      = 6'h00;
      div_inc    = 5'h00;
      div_out    = 1'b0;
      tach_src   = 1'b0;
      nxt_st     = st_ff;
      tc         = st_ff.cfg[`LSDCR_CFG_TACH];
      rise       = sclk & ~st_ff.spi.sclk_q;
      fall       = ~sclk & st_ff.spi.sclk_q;
      nxt_st.spi.sclk_q = sclk;
      nxt_st.aux_onoff[`LSDCR_AUX_INTRST] = 1'b0;

      // Serial port: shift in on rising, shift out on falling clock
      if (cs_n) begin
         nxt_st.spi.bit_cnt = 5'h00;
      end else if (rise && st_ff.spi.bit_cnt != `LSDCR_FRM_BITS) begin
         word = {st_ff.spi.rx[14:0], mosi};
         nxt_st.spi.rx      = word;
         nxt_st.spi.bit_cnt = st_ff.spi.bit_cnt + 5'h01;
         // Last bit: decode, commit a write, load the answer for the next frame
         if (st_ff.spi.bit_cnt == `LSDCR_FRM_BITS - 5'h01) begin
            space = word[`LSDCR_FRM_SPACE_HI:`LSDCR_FRM_SPACE_LO];
            idx   = word[`LSDCR_FRM_REG_HI:`LSDCR_FRM_REG_LO];
            if (space == `LSDCR_SPACE_CFG && idx <= `LSDCR_CFG_LAST) begin
               rdata = st_ff.cfg[idx[2:0]];
               if (word[`LSDCR_FRM_WRITE]) begin
                  nxt_st.cfg[idx[2:0]] = word[7:0] & cfg_mask(idx);
               end
            end else if (space == `LSDCR_SPACE_CTL && idx == `LSDCR_CTL_MAIN) begin
               rdata = st_ff.main_onoff;
               if (word[`LSDCR_FRM_WRITE]) begin
                  nxt_st.main_onoff = word[7:0];
               end
            end else if (space == `LSDCR_SPACE_CTL && idx == `LSDCR_CTL_AUX) begin
               rdata = st_ff.aux_onoff;
               if (word[`LSDCR_FRM_WRITE]) begin
                  nxt_st.aux_onoff = word[7:0] & `LSDCR_AUX_MASK;
               end
            end else if (space == `LSDCR_SPACE_CTL && idx >= `LSDCR_CTL_DUTY_FIRST) begin
               duty_idx = 7'(idx - `LSDCR_CTL_DUTY_FIRST);
               rdata    = {1'b0, st_ff.duty[duty_idx[2:0]]};
               if (word[`LSDCR_FRM_WRITE]) begin
                  nxt_st.duty[duty_idx[2:0]] = word[6:0];
               end
            end
            nxt_st.spi.tx = {word[15:8], rdata};
         end
      end else if (fall && st_ff.spi.bit_cnt != 5'h00 &&
                   st_ff.spi.bit_cnt != `LSDCR_FRM_BITS) begin
         nxt_st.spi.tx = {st_ff.spi.tx[14:0], 1'b0};
      end

      // Shared PWM time bases: 100 steps of 1 % each
      if (st_ff.pre_low >= LOW_STEP_M1) begin
         nxt_st.pre_low = 14'h0000;
         if (st_ff.pct_low >= `LSDCR_DUTY_FULL - 7'h01) begin
            nxt_st.pct_low = 7'h00;
            low_wrap       = 1'b1;
         end else begin
            nxt_st.pct_low = st_ff.pct_low + 7'h01;
         end
      end else begin
         nxt_st.pre_low = st_ff.pre_low + 14'h0001;
      end
      if (st_ff.pre_high >= HIGH_STEP_M1) begin
         nxt_st.pre_high = 14'h0000;
         if (st_ff.pct_high >= `LSDCR_DUTY_FULL - 7'h01) begin
            nxt_st.pct_high = 7'h00;
            high_wrap       = 1'b1;
         end else begin
            nxt_st.pct_high = st_ff.pct_high + 7'h01;
         end
      end else begin
         nxt_st.pre_high = st_ff.pre_high + 14'h0001;
      end

      // Fixed oscillator
      if (st_ff.osc_cnt >= osc_half_m1(tc[2:0])) begin
         nxt_st.osc_cnt = 23'h000000;
         nxt_st.osc_out = ~st_ff.osc_out;
      end else begin
         nxt_st.osc_cnt = st_ff.osc_cnt + 23'h000001;
      end

      // Speed-pulse divider: output spans N input periods
      nxt_st.speed_q = speed_pulse;
      speed_rise     = speed_pulse & ~st_ff.speed_q;
      div_n          = (tc[4:0] == 5'h00) ? 6'h20 : {1'b0, tc[4:0]};
      div_inc        = st_ff.div_cnt + 5'h01;
      if (speed_rise) begin
         nxt_st.div_cnt = ({1'b0, div_inc} >= div_n) ? 5'h00 : div_inc;
      end else if ({1'b0, st_ff.div_cnt} >= div_n) begin
         nxt_st.div_cnt = 5'h00;
      end
      div_out = (div_n == 6'h01) ? st_ff.speed_q
                                 : ({1'b0, st_ff.div_cnt} < {1'b0, div_n[5:1]});

      // Tachometer source follows the live mode field
      unique case (tach_mode)
         LSDCR_TM_DIV: tach_src = div_out;
         LSDCR_TM_OSC: tach_src = st_ff.osc_out;
         LSDCR_TM_LSD: begin
            unique case (tc[1:0])
               2'b01:   tach_src = duty_low_hi[4];
               2'b10:   tach_src = duty_high_hi[4];
               default: tach_src = 1'b1;
            endcase
         end
      endcase

      // Overcurrent latches the tach off; retry rearms at PWM period start
      if (tach_overcurrent && st_ff.drive.tach_output) begin
         nxt_st.tach_trip = 1'b1;
      end else if (!st_ff.aux_onoff[`LSDCR_AUX_TACH] ||
                   (tc[`LSDCR_CFG_RETRY] && (low_wrap || high_wrap))) begin
         nxt_st.tach_trip = 1'b0;
      end

      nxt_st.drive = lsdcr_drive_t'({st_ff.aux_onoff[`LSDCR_AUX_TACH] & ~st_ff.tach_trip
                                     & tach_src,
                                     drv_nxt[5], drv_nxt[3], drv_nxt[2],
                                     drv_nxt[1], drv_nxt[0]});

      // Diagnostic controls follow each driver's configuration
      for (int i = 0; i < 6; i++) begin
         nxt_st.diag.retry_en[i]    = st_ff.cfg[i][`LSDCR_CFG_RETRY];
         nxt_st.diag.sink_en[i]     = st_ff.cfg[i][`LSDCR_CFG_SINK];
         nxt_st.diag.inrush_long[i] = st_ff.cfg[i][`LSDCR_CFG_INRUSH];
      end
      nxt_st.diag.sink_en[4]     = tach_lsd & tc[`LSDCR_CFG_SINK];
      nxt_st.diag.inrush_long[4] = tach_lsd & tc[`LSDCR_CFG_INRUSH];
      nxt_st.diag.open_load_flag = open_load_raw & nxt_st.diag.sink_en;

      // System and pre-driver commands
      nxt_st.sys.power_hold_en     = st_ff.aux_onoff[`LSDCR_AUX_PWRHOLD];
      nxt_st.sys.power_on_selftest = st_ff.aux_onoff[`LSDCR_AUX_SELFTEST];
      nxt_st.sys.sensor_supply_on  = st_ff.aux_onoff[`LSDCR_AUX_VSENS];
      nxt_st.sys.battery_switch_on = st_ff.aux_onoff[`LSDCR_AUX_BATSW];
      nxt_st.sys.internal_reset    = st_ff.aux_onoff[`LSDCR_AUX_INTRST];
      nxt_st.sys.spark_a_on        = st_ff.main_onoff[`LSDCR_MAIN_SPARK_A];
      nxt_st.sys.spark_b_on        = st_ff.main_onoff[`LSDCR_MAIN_SPARK_B];
      nxt_st.sys.heater_on         = st_ff.main_onoff[`LSDCR_MAIN_HEATER];
   end

   // Reset loads the defaults; ce low freezes every register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff            <= '0;
         st_ff.cfg        <= {`LSDCR_LAMP_CFG_RST, `LSDCR_TACH_CFG_RST,
                              `LSDCR_CFG_RST, `LSDCR_CFG_RST,
                              `LSDCR_CFG_RST, `LSDCR_CFG_RST};
         st_ff.main_onoff <= `LSDCR_MAIN_RST;
         st_ff.aux_onoff  <= `LSDCR_AUX_RST;
         st_ff.duty       <= {6{`LSDCR_DUTY_RST}};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

endmodule // lsdcr_regs
